// ### verilog/bus_cycle_map.vh
// Constants of the bus cycle sequencer: cycle codes, machine states, status encodings.
// Assumes inclusion by bare name from design files under verilog/.
`ifndef BUS_CYCLE_MAP_VH
`define BUS_CYCLE_MAP_VH

// Cycle type requests from the core
`define CYC_OPCODE_FETCH 3'h0
`define CYC_MEMORY_READ 3'h1
`define CYC_MEMORY_WRITE 3'h2
`define CYC_IO_READ 3'h3
`define CYC_IO_WRITE 3'h4
`define CYC_INT_ACK 3'h5
`define CYC_BUS_IDLE 3'h6

// Machine states
`define ST_T1 4'h0
`define ST_T2 4'h1
`define ST_WAIT 4'h2
`define ST_T3 4'h3
`define ST_T4 4'h4
`define ST_T5 4'h5
`define ST_T6 4'h6
`define ST_RESET 4'h7
`define ST_HALT 4'h8
`define ST_HOLD 4'h9

// Select/status1/status0 codes
`define SEL_OPCODE_FETCH 3'h3
`define SEL_MEMORY_READ 3'h2
`define SEL_MEMORY_WRITE 3'h1
`define SEL_IO_READ 3'h6
`define SEL_IO_WRITE 3'h5
`define SEL_INT_ACK 3'h7
`define SEL_IDLE_DOUBLE_ADD 3'h2
`define SEL_IDLE_RESTART 3'h7

// Interrupt source bit positions in the synchronised vector
`define INT_NMI 0
`define INT_HIGH 1
`define INT_MID 2
`define INT_LOW 3
`define INT_GENERAL 4
`define INT_COUNT 5

`endif

// ### verilog/input_sync.v
// Two-flop synchroniser for a group of asynchronous level inputs.
// Assumes inputs come from pins outside the clock domain.
`timescale 1ns/1ps
module input_sync #(
   parameter WIDTH = 6
) (
   input wire clk, // System clock
   input wire rstn, // Asynchronous reset, active low
   input wire [WIDTH-1:0] async_in, // Raw pin levels
   output wire [WIDTH-1:0] sync_out // Synchronised levels
);

reg [WIDTH-1:0] stage1;
reg [WIDTH-1:0] stage2;

// Two stages per bit
always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
   end else begin
      stage1 <= async_in;
      stage2 <= stage1;
   end
end

assign sync_out = stage2;

endmodule

// ### verilog/cycle_decode.v
// Decoder from a cycle request to its select/status code and active strobe.
// Assumes the cycle code and idle flavour come from the sequencer.
`timescale 1ns/1ps
`include "bus_cycle_map.vh"
module cycle_decode (
   input wire [2:0] cycle_type, // Requested machine cycle type
   input wire idle_restart, // Idle cycle belongs to restart/nmi acknowledge
   output reg [2:0] sel_status, // Select, status1, status0
   output reg read_active, // Cycle uses read strobe
   output reg write_active, // Cycle uses write strobe
   output reg ack_active // Cycle uses acknowledge strobe
);

// Encoding per cycle type
always @* begin
   sel_status = `SEL_IDLE_DOUBLE_ADD;
   read_active = 1'b0;
   write_active = 1'b0;
   ack_active = 1'b0;
   case (cycle_type)
      `CYC_OPCODE_FETCH: begin
         sel_status = `SEL_OPCODE_FETCH;
         read_active = 1'b1;
      end
      `CYC_MEMORY_READ: begin
         sel_status = `SEL_MEMORY_READ;
         read_active = 1'b1;
      end
      `CYC_MEMORY_WRITE: begin
         sel_status = `SEL_MEMORY_WRITE;
         write_active = 1'b1;
      end
      `CYC_IO_READ: begin
         sel_status = `SEL_IO_READ;
         read_active = 1'b1;
      end
      `CYC_IO_WRITE: begin
         sel_status = `SEL_IO_WRITE;
         write_active = 1'b1;
      end
      `CYC_INT_ACK: begin
         sel_status = `SEL_INT_ACK;
         ack_active = 1'b1;
      end
      `CYC_BUS_IDLE: begin
         sel_status = idle_restart ? `SEL_IDLE_RESTART : `SEL_IDLE_DOUBLE_ADD;
      end
      default: begin
         sel_status = `SEL_IDLE_DOUBLE_ADD;
      end
   endcase
end

endmodule

// ### verilog/bus_cycle_seq.v
// Bus cycle sequencer: T-state machine, status/strobe pins, power-down control.
// Assumes a core issues one cycle request per machine cycle via cyc_start.
`timescale 1ns/1ps
`include "bus_cycle_map.vh"
// Behaviour
// - Pulse address latch strobe so low eight address bits can be captured
// - I/O cycles drive the port number on upper and low lines
// - Select and status at T1; read/write strobes only during transfer
// - Cycles last three T states; opcode fetch and interrupt acknowledge four or six
// - Wait states while ready low; hold states while hold requested
// - Every T state is one of ten machine states
// - Seven cycle types identified by select, status and strobes
// - Select/status encodings and active strobe per cycle type
// - T1 latch strobe high; T4-T6 float low bus, status 11
// - Reset, halt, hold float select, address, strobes; ack high
// - No latch strobe in second and third double add cycles
// - Power-down entered by halt instruction or hold input
// - Halt power-down ends only on reset or accepted interrupt
// - Hold power-down ignores interrupts; ends on reset or hold release
// - Release sources: hold, reset, nmi, three restarts, general request
// - Low address in first T state, data in T2, wait states and T3
// - Hold and interrupts synchronised to internal clock
module bus_cycle_seq (
   input wire clk, // System clock, 10 MHz
   input wire rstn, // Asynchronous reset, active low
   input wire cyc_start, // Core requests a machine cycle
   input wire [2:0] cyc_type, // Requested cycle type
   input wire cyc_six, // Opcode fetch takes six T states
   input wire cyc_no_latch, // Second/third cycle of double add
   input wire cyc_idle_restart, // Idle cycle of restart/nmi acknowledge
   input wire cyc_halt, // Core executes halt
   input wire [15:0] cyc_addr, // Cycle address
   input wire [7:0] cyc_wdata, // Write data
   input wire ready, // Ready pin, high when ready
   input wire hold, // Hold request pin
   input wire nmi_int, // Nonmaskable interrupt pin
   input wire restart_int_high, // Highest restart interrupt pin
   input wire restart_int_mid, // Middle restart interrupt pin
   input wire restart_int_low, // Low restart interrupt pin
   input wire general_int_request, // General interrupt request pin
   input wire [7:0] ad_in, // Address/data bus input
   output reg [7:0] ad_out, // Address/data bus output
   output reg ad_oe, // Address/data drive enable
   output reg [7:0] addr_high, // Upper address lines
   output reg addr_high_oe, // Upper address drive enable
   output reg io_mem_select, // Memory/IO select, high for IO
   output reg ctl_oe, // Select/read/write drive enable
   output reg cycle_status_bit1, // Cycle status bit 1
   output reg cycle_status_bit0, // Cycle status bit 0
   output reg read_strobe_n, // Read strobe, active low
   output reg write_strobe_n, // Write strobe, active low
   output reg int_ack_strobe_n, // Interrupt acknowledge strobe, active low
   output reg addr_latch_strobe, // Address latch strobe, active high
   output reg hold_ack, // Bus granted to external side
   output reg power_down, // Power-down condition active
   output reg [3:0] machine_state, // Current machine state
   output reg cyc_done, // One-cycle pulse at end of machine cycle
   output reg [7:0] rdata, // Data captured on reads
   output reg int_wake, // Pulse: interrupt released halt power-down
   output reg [4:0] int_sync // Synchronised interrupt levels
);

//--------------------------------------------------------------
// Input synchronisation
//--------------------------------------------------------------
wire [5:0] sync_vec;
wire ready_s;
wire hold_s;
wire [4:0] ints_s;

// Ready, hold and interrupts through two flops
input_sync #(.WIDTH(7 - 1)) u_sync (
   .clk(clk),
   .rstn(rstn),
   .async_in({hold, general_int_request, restart_int_low, restart_int_mid, restart_int_high, nmi_int}),
   .sync_out(sync_vec)
);

reg [1:0] ready_pipe;
always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      ready_pipe <= 2'b00;
   end else begin
      ready_pipe <= {ready_pipe[0], ready};
   end
end

assign ready_s = ready_pipe[1];
assign hold_s = sync_vec[5];
assign ints_s = sync_vec[4:0];

//--------------------------------------------------------------
// Cycle decoding
//--------------------------------------------------------------
reg [2:0] cur_type;
reg cur_six;
reg cur_no_latch;
reg cur_idle_restart;
reg [7:0] cur_wdata;
wire [2:0] sel_status;
wire rd_act;
wire wr_act;
wire ack_act;

cycle_decode u_dec (
   .cycle_type(cur_type),
   .idle_restart(cur_idle_restart),
   .sel_status(sel_status),
   .read_active(rd_act),
   .write_active(wr_act),
   .ack_active(ack_act)
);

// True for port cycles, which copy port number on both halves
function is_io;
   input [2:0] t;
   begin
      is_io = (t == `CYC_IO_READ) || (t == `CYC_IO_WRITE);
   end
endfunction

// Whether a state is outside a machine cycle
function nx_float_prev;
   input [3:0] s;
   begin
      nx_float_prev = (s == `ST_RESET) || (s == `ST_HALT) || (s == `ST_HOLD);
   end
endfunction

//--------------------------------------------------------------
// State machine
//--------------------------------------------------------------
reg [3:0] state;
reg [3:0] next_state;
reg halt_pd; // Power-down entered through halt
reg hold_pd; // Power-down entered through hold

wire any_int = |ints_s;

// Next state
always @* begin
   next_state = state;
   case (state)
      `ST_RESET: next_state = cyc_start ? `ST_T1 : `ST_RESET;
      `ST_T1: next_state = `ST_T2;
      `ST_T2, `ST_WAIT: next_state = ready_s ? `ST_T3 : `ST_WAIT;
      `ST_T3: begin
         if (cur_type == `CYC_OPCODE_FETCH || cur_type == `CYC_INT_ACK) begin
            next_state = `ST_T4;
         end else if (hold_s) begin
            next_state = `ST_HOLD;
         end else begin
            next_state = `ST_RESET;
         end
      end
      `ST_T4: begin
         if (cur_six) begin
            next_state = `ST_T5;
         end else if (hold_s) begin
            next_state = `ST_HOLD;
         end else begin
            next_state = `ST_RESET;
         end
      end
      `ST_T5: next_state = `ST_T6;
      `ST_T6: next_state = hold_s ? `ST_HOLD : `ST_RESET;
      `ST_HALT: next_state = any_int ? `ST_RESET : `ST_HALT;
      `ST_HOLD: begin
         if (hold_pd) begin
            next_state = hold_s ? `ST_HOLD : `ST_RESET;
         end else begin
            next_state = any_int ? `ST_RESET : `ST_HOLD;
         end
      end
      default: next_state = `ST_RESET;
   endcase
   // Idle between cycles: halt or hold requests
   if (state == `ST_RESET && !cyc_start) begin
      if (hold_s) begin
         next_state = `ST_HOLD;
      end else if (cyc_halt) begin
         next_state = `ST_HALT;
      end
   end
end

// State register and cycle capture
always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      state <= `ST_RESET;
      cur_type <= `CYC_BUS_IDLE;
      cur_six <= 1'b0;
      cur_no_latch <= 1'b0;
      cur_idle_restart <= 1'b0;
      cur_wdata <= 8'h00;
      halt_pd <= 1'b0;
      hold_pd <= 1'b0;
   end else begin
      state <= next_state;
      if (state == `ST_RESET && next_state == `ST_T1) begin
         cur_type <= cyc_type;
         cur_six <= cyc_six;
         cur_no_latch <= cyc_no_latch;
         cur_idle_restart <= cyc_idle_restart;
         cur_wdata <= cyc_wdata;
      end
      // Halt power-down holds itself; hold release ignored
      if (next_state == `ST_HALT) begin
         halt_pd <= 1'b1;
      end else if (next_state == `ST_RESET) begin
         halt_pd <= 1'b0;
      end
      if (next_state == `ST_HOLD && !halt_pd && state != `ST_HALT) begin
         hold_pd <= 1'b1;
      end else if (next_state != `ST_HOLD) begin
         hold_pd <= 1'b0;
      end
   end
end

//--------------------------------------------------------------
// Pin drive
//--------------------------------------------------------------
wire nx_t1 = (next_state == `ST_T1);
wire nx_xfer = (next_state == `ST_T2) || (next_state == `ST_WAIT) || (next_state == `ST_T3);
wire nx_late = (next_state == `ST_T4) || (next_state == `ST_T5) || (next_state == `ST_T6);
wire nx_float = (next_state == `ST_RESET) || (next_state == `ST_HALT) || (next_state == `ST_HOLD);
wire [2:0] start_sel;

// Encoding for the cycle being launched this edge
cycle_decode u_dec_start (
   .cycle_type(cyc_type),
   .idle_restart(cyc_idle_restart),
   .sel_status(start_sel),
   .read_active(),
   .write_active(),
   .ack_active()
);

// Registered outputs follow the next state
always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      ad_out <= 8'h00;
      ad_oe <= 1'b0;
      addr_high <= 8'h00;
      addr_high_oe <= 1'b0;
      io_mem_select <= 1'b0;
      ctl_oe <= 1'b0;
      cycle_status_bit1 <= 1'b0;
      cycle_status_bit0 <= 1'b0;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      int_ack_strobe_n <= 1'b1;
      addr_latch_strobe <= 1'b0;
      hold_ack <= 1'b0;
      power_down <= 1'b0;
      machine_state <= `ST_RESET;
      cyc_done <= 1'b0;
      rdata <= 8'h00;
      int_wake <= 1'b0;
      int_sync <= 5'h00;
   end else begin
      machine_state <= next_state;
      int_sync <= ints_s;
      hold_ack <= (next_state == `ST_HOLD);
      power_down <= (next_state == `ST_HALT) || (next_state == `ST_HOLD);
      int_wake <= halt_pd && any_int && (next_state == `ST_RESET);
      cyc_done <= nx_float && !nx_float_prev(state);
      if (nx_t1) begin
         // T1: status, select, address out, latch strobe high unless cyc_no_latch
         {io_mem_select, cycle_status_bit1, cycle_status_bit0} <= start_sel;
         ctl_oe <= 1'b1;
         addr_high <= is_io(cyc_type) ? cyc_addr[7:0] : cyc_addr[15:8];
         addr_high_oe <= 1'b1;
         ad_out <= cyc_addr[7:0];
         ad_oe <= 1'b1;
         addr_latch_strobe <= !cyc_no_latch;
         read_strobe_n <= 1'b1;
         write_strobe_n <= 1'b1;
         int_ack_strobe_n <= 1'b1;
      end else if (nx_xfer) begin
         // Transfer phase: only the matching strobe falls
         addr_latch_strobe <= 1'b0;
         read_strobe_n <= !rd_act;
         write_strobe_n <= !wr_act;
         int_ack_strobe_n <= !ack_act;
         ad_out <= cur_wdata;
         ad_oe <= wr_act;
      end else if (nx_late) begin
         // T4-T6: low bus floats, status 11
         addr_latch_strobe <= 1'b0;
         read_strobe_n <= 1'b1;
         write_strobe_n <= 1'b1;
         int_ack_strobe_n <= 1'b1;
         ad_oe <= 1'b0;
         cycle_status_bit1 <= 1'b1;
         cycle_status_bit0 <= 1'b1;
         io_mem_select <= (cur_type == `CYC_INT_ACK);
      end else begin
         // Reset, halt, hold: floats, ack high, latch low
         addr_latch_strobe <= 1'b0;
         read_strobe_n <= 1'b1;
         write_strobe_n <= 1'b1;
         int_ack_strobe_n <= 1'b1;
         ad_oe <= 1'b0;
         addr_high_oe <= 1'b0;
         ctl_oe <= 1'b0;
         if (next_state == `ST_HALT) begin
            cycle_status_bit1 <= 1'b0;
            cycle_status_bit0 <= 1'b0;
         end
      end
      // Capture read data at the end of T3
      if (state == `ST_T3 && rd_act) begin
         rdata <= ad_in;
      end
   end
end

endmodule

// ### sim/bus_cycle_seq_assertions.sv
// Pin checker of the bus cycle sequencer.
// Assumes it is bound to the sequencer, whose constants come from the map header.
`timescale 1ns/1ps
`include "bus_cycle_map.vh"
module bus_cycle_seq_assertions (
   input wire clk, // System clock
   input wire rstn, // Reset, active low
   input wire [3:0] machine_state, // Current state
   input wire addr_latch_strobe, // Latch strobe
   input wire read_strobe_n, // Read strobe
   input wire write_strobe_n, // Write strobe
   input wire int_ack_strobe_n, // Acknowledge strobe
   input wire ctl_oe, // Control drive enable
   input wire ad_oe, // Low bus drive enable
   input wire addr_high_oe, // High bus drive enable
   input wire io_mem_select, // Memory/IO select
   input wire cycle_status_bit1, // Status bit 1
   input wire cycle_status_bit0, // Status bit 0
   input wire power_down, // Power-down flag
   input wire hold_ack // Bus granted
);
   // ---------------------------------------------
   // Properties on the bus pins
   // ---------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Latch strobe and strobes around T1
   a_latch_only_t1: assert property (addr_latch_strobe |-> machine_state == `ST_T1)
      else $error("latch strobe outside T1");
   a_latch_one_cycle: assert property (addr_latch_strobe |=> !addr_latch_strobe)
      else $error("latch strobe longer than one cycle");
   a_t1_strobes_off: assert property (machine_state == `ST_T1
      |-> read_strobe_n && write_strobe_n && int_ack_strobe_n)
      else $error("strobe active in T1");
   a_strobe_xfer: assert property (!read_strobe_n || !write_strobe_n || !int_ack_strobe_n
      |-> machine_state inside {`ST_T2, `ST_WAIT, `ST_T3})
      else $error("strobe active outside transfer");
   // Sequence and status timing
   a_t2_after_t1: assert property (machine_state == `ST_T1 |=> machine_state == `ST_T2)
      else $error("T1 not followed by T2");
   a_status_held: assert property (machine_state == `ST_T2
      |-> $stable({io_mem_select, cycle_status_bit1, cycle_status_bit0}))
      else $error("status changed after T1");
   a_late_float: assert property (machine_state inside {`ST_T4, `ST_T5, `ST_T6}
      |-> !ad_oe && cycle_status_bit1 && cycle_status_bit0 && read_strobe_n && write_strobe_n)
      else $error("T4 to T6 pins wrong");
   a_late_select: assert property (machine_state == `ST_T4 |-> io_mem_select == $past(io_mem_select))
      else $error("select changed entering T4");
   a_idle_float: assert property (machine_state inside {`ST_RESET, `ST_HALT, `ST_HOLD}
      |-> !ctl_oe && !ad_oe && !addr_high_oe && int_ack_strobe_n && !addr_latch_strobe)
      else $error("pins driven in reset, halt or hold");
   a_halt_status: assert property (machine_state == `ST_HALT
      |-> !cycle_status_bit1 && !cycle_status_bit0 && power_down)
      else $error("halt status wrong");
   a_hold_granted: assert property (machine_state == `ST_HOLD |-> hold_ack && power_down)
      else $error("hold state without grant");
   a_state_legal: assert property (machine_state <= `ST_HOLD)
      else $error("illegal machine state");
endmodule
bind bus_cycle_seq bus_cycle_seq_assertions bus_cycle_seq_assertions_i (.clk, .rstn, .machine_state,
   .addr_latch_strobe, .read_strobe_n, .write_strobe_n, .int_ack_strobe_n, .ctl_oe, .ad_oe, .addr_high_oe,
   .io_mem_select, .cycle_status_bit1, .cycle_status_bit0, .power_down, .hold_ack);

// ### sim/ext_bus_model.sv
// Model of memory, I/O ports and address latch on the far side of the sequencer.
// Assumes the sequencer pins of the same names; slow sets extra not-ready cycles.
`timescale 1ns/1ps
module ext_bus_model (
   input wire clk, // System clock
   input wire [7:0] ad_out, // Low bus from the device
   input wire addr_latch_strobe, // Latch strobe
   input wire read_strobe_n, // Read strobe
   input wire write_strobe_n, // Write strobe
   input wire [2:0] slow, // Not-ready cycles per transfer
   output wire ready, // Ready pin
   output wire [7:0] ad_in, // Low bus to the device
   output reg [7:0] wr_seen = 8'h00 // Last byte written
);
   reg [7:0] latched = 8'h00;
   reg [7:0] junk = 8'h00;
   reg [2:0] cnt = 3'h0;
   // Latch the low address, pace ready, capture write data
   always @(posedge clk) begin
      junk <= ~junk;
      if (addr_latch_strobe) begin
         latched <= ad_out;
      end
      if (read_strobe_n && write_strobe_n) begin
         cnt <= slow;
      end else if (cnt != 3'h0) begin
         cnt <= cnt - 3'h1;
      end
      if (!write_strobe_n) begin
         wr_seen <= ad_out;
      end
   end
   // Ready low until the slow count runs out
   assign ready = (cnt == 3'h0);
   // Data only while read is low, else a pattern that flips each cycle
   assign ad_in = read_strobe_n ? junk : (latched ^ 8'h5A);
endmodule

// ### sim/tb_top.sv
// Self-checking bench of the bus cycle sequencer with its bus partner.
// Assumes the sequencer, its checker and the partner model are compiled first.
`timescale 1ns/1ps
`include "bus_cycle_map.vh"
module tb_top;
   reg clk = 1'b0;
   reg rstn = 1'b0;
   reg cyc_start = 1'b0;
   reg [2:0] cyc_type = 3'h0;
   reg cyc_six = 1'b0;
   reg cyc_no_latch = 1'b0;
   reg cyc_idle_restart = 1'b0;
   reg cyc_halt = 1'b0;
   reg [15:0] cyc_addr = 16'h0000;
   reg [7:0] cyc_wdata = 8'h00;
   reg hold = 1'b0;
   reg [4:0] irq = 5'h00;
   reg [2:0] slow = 3'h0;
   wire ready, ad_oe, addr_high_oe, io_mem_select, ctl_oe, cycle_status_bit1, cycle_status_bit0;
   wire read_strobe_n, write_strobe_n, int_ack_strobe_n, addr_latch_strobe, hold_ack, power_down;
   wire cyc_done, int_wake;
   wire [7:0] ad_in, ad_out, addr_high, rdata, wr_seen;
   wire [3:0] machine_state;
   wire [4:0] int_sync;
   integer miscompares = 0;
   integer cmp_count = 0;
   integer wake_cnt = 0;
   integer n_t, n_w, i, w0;
   reg [5:0] code;
   reg latch;
   reg [7:0] ahi, alo;
   // -----------------------------------
   // Design, partner and clock
   // -----------------------------------
   bus_cycle_seq bus_cycle_seq_i (.*, .nmi_int(irq[`INT_NMI]), .restart_int_high(irq[`INT_HIGH]),
      .restart_int_mid(irq[`INT_MID]), .restart_int_low(irq[`INT_LOW]),
      .general_int_request(irq[`INT_GENERAL]));
   ext_bus_model ext_bus_model_i (.*);
   always #50 clk = ~clk;
   // Count wake pulses
   always @(posedge clk) if (int_wake === 1'b1) wake_cnt <= wake_cnt + 1;
   // -----------------------------------
   // Helpers
   // -----------------------------------
   task chk(input string name, input [15:0] got, input [15:0] exp);
      begin
         cmp_count++;
         if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   task step;
      begin
         @(posedge clk);
         #1;
      end
   endtask
   task wait_st(input [3:0] s);
      integer k;
      begin
         k = 0;
         while (machine_state !== s && k < 20) begin
            step;
            k++;
         end
      end
   endtask
   function [5:0] exp_code(input [2:0] t, input r);
      case (t)
         `CYC_OPCODE_FETCH: exp_code = {`SEL_OPCODE_FETCH, 3'h3};
         `CYC_MEMORY_READ: exp_code = {`SEL_MEMORY_READ, 3'h3};
         `CYC_MEMORY_WRITE: exp_code = {`SEL_MEMORY_WRITE, 3'h5};
         `CYC_IO_READ: exp_code = {`SEL_IO_READ, 3'h3};
         `CYC_IO_WRITE: exp_code = {`SEL_IO_WRITE, 3'h5};
         `CYC_INT_ACK: exp_code = {`SEL_INT_ACK, 3'h6};
         default: exp_code = {r ? `SEL_IDLE_RESTART : `SEL_IDLE_DOUBLE_ADD, 3'h7};
      endcase
   endfunction
   // One machine cycle, recording T1 pins, strobes, length and waits
   task run_cyc(input [2:0] t, input six, input nl, input rs, input [15:0] a);
      begin
         cyc_type = t;
         cyc_six = six;
         cyc_no_latch = nl;
         cyc_idle_restart = rs;
         cyc_addr = a;
         cyc_wdata = ~a[7:0];
         cyc_start = 1'b1;
         step;
         cyc_start = 1'b0;
         n_t = 0;
         n_w = 0;
         code = 6'h3f;
         latch = 1'b0;
         while (machine_state === `ST_RESET && n_t < 3) begin
            step;
            n_t++;
         end
         n_t = 0;
         while (machine_state !== `ST_RESET && n_t + n_w < 40) begin
            if (machine_state === `ST_T1) begin
               code[5:3] = {io_mem_select, cycle_status_bit1, cycle_status_bit0};
               ahi = addr_high;
               alo = ad_out;
            end
            code[2:0] = code[2:0] & {read_strobe_n, write_strobe_n, int_ack_strobe_n};
            latch = latch | addr_latch_strobe;
            if (machine_state === `ST_WAIT) n_w++;
            else n_t++;
            step;
         end
         chk("done pulse", cyc_done, 1);
      end
   endtask
   // -----------------------------------
   // Scenarios
   // -----------------------------------
   task test_cycles;
      reg [2:0] t;
      begin
         for (i = 0; i < 9; i++) begin
            t = (i > 7) ? 3'h6 : ((i == 0) ? 3'h0 : i - 1);
            run_cyc(t, i == 1, 1'b0, i == 8, {8'h40 + i[7:0], 8'h30 + i[7:0]});
            chk("length", n_t, (t == `CYC_OPCODE_FETCH || t == `CYC_INT_ACK) ? ((i == 1) ? 6 : 4) : 3);
            chk("code", code, exp_code(t, i == 8));
            if (t != `CYC_BUS_IDLE) begin
               chk("latch", latch, 1);
               chk("low addr", alo, cyc_addr[7:0]);
               chk("high addr", ahi, (t == `CYC_IO_READ || t == `CYC_IO_WRITE) ? cyc_addr[7:0] : cyc_addr[15:8]);
            end
            if (!code[2]) chk("read data", rdata, cyc_addr[7:0] ^ 8'h5A);
            if (!code[1]) chk("write data", wr_seen, cyc_wdata);
         end
         $display("test_cycles done");
      end
   endtask
   task test_wait_dad;
      begin
         slow = 3'h4;
         repeat (2) step;
         run_cyc(`CYC_MEMORY_READ, 1'b0, 1'b0, 1'b0, 16'h5566);
         chk("waits seen", n_w != 0, 1);
         chk("length", n_t, 3);
         chk("read data", rdata, 8'h66 ^ 8'h5A);
         slow = 3'h0;
         run_cyc(`CYC_MEMORY_READ, 1'b0, 1'b1, 1'b0, 16'h7788);
         chk("no latch", latch, 0);
         $display("test_wait_dad done");
      end
   endtask
   task test_hold;
      begin
         hold = 1'b1;
         wait_st(`ST_HOLD);
         chk("hold state", machine_state, `ST_HOLD);
         chk("hold power", power_down, 1);
         chk("hold grant", hold_ack, 1);
         irq = 5'h1f;
         repeat (6) step;
         chk("irq ignored", machine_state, `ST_HOLD);
         chk("int sync", int_sync, 5'h1f);
         irq = 5'h00;
         repeat (4) step;
         hold = 1'b0;
         wait_st(`ST_RESET);
         step;
         chk("hold left", power_down, 0);
         $display("test_hold done");
      end
   endtask
   task test_halt;
      begin
         cyc_halt = 1'b1;
         wait_st(`ST_HALT);
         chk("halt power", power_down, 1);
         hold = 1'b1;
         repeat (6) step;
         hold = 1'b0;
         repeat (6) step;
         chk("halt kept", machine_state, `ST_HALT);
         for (i = 0; i < 5; i++) begin
            w0 = wake_cnt;
            irq[i] = 1'b1;
            wait_st(`ST_RESET);
            step;
            chk("wake pulse", wake_cnt != w0, 1);
            irq[i] = 1'b0;
            repeat (4) step;
            wait_st(`ST_HALT);
         end
         rstn = 1'b0;
         step;
         chk("reset exit", machine_state, `ST_RESET);
         chk("reset power", power_down, 0);
         cyc_halt = 1'b0;
         rstn = 1'b1;
         step;
         $display("test_halt done");
      end
   endtask
   task end_sim;
      begin
         $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
         if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask
   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      #1;
      rstn = 1'b1;
      step;
      test_cycles;
      test_wait_dad;
      test_hold;
      test_halt;
      end_sim;
   end
   // Watchdog, far beyond the expected run
   initial begin
      #(100 * 6000);
      miscompares++;
      end_sim;
   end
endmodule
